// ===== design/sad_defines.vh
// Purpose: Shared constants for the serial auto-baud detect block
// Assumes: 32-bit APB data, one word per register
// Notes:   Offsets are byte addresses
`ifndef SAD_DEFINES_VH
`define SAD_DEFINES_VH

// Register byte offsets
`define SAD_OFF_CTRL       8'h00
`define SAD_OFF_RATE_LOW   8'h04
`define SAD_OFF_RATE_HIGH  8'h08
`define SAD_OFF_RX_BUF     8'h0C
`define SAD_OFF_INT_STAT   8'h10
`define SAD_OFF_INT_MASK   8'h14
`define SAD_OFF_STATUS     8'h18

// rate_control_reg fields
`define SAD_CTRL_AB_EN     0
`define SAD_CTRL_WIDE      1
`define SAD_CTRL_HIGH      2
`define SAD_CTRL_WAKE      3
`define SAD_CTRL_W         4

// Interrupt status fields
`define SAD_INT_RX_FLAG    0
`define SAD_INT_CAL_DONE   1
`define SAD_INT_OVERFLOW   2
`define SAD_INT_W          3

// Reset values
`define SAD_CTRL_RST       4'h0
`define SAD_RATE_RST       8'h00
`define SAD_MASK_RST       3'h0

// Prescale ratios as log2 of the divisor: base ratios from the system clock, auto-baud extra from the base clock
`define SAD_BASE_SLOW_LOG2 4'h6
`define SAD_BASE_MID_LOG2  4'h4
`define SAD_BASE_FAST_LOG2 4'h2
`define SAD_ABD_EXTRA_LOG2 4'h3

// Sync character shape: rising edges per measured character; start value of the measurement counter
`define SAD_EDGE_COUNT     3'h5
`define SAD_COUNT_START    16'h0001

`endif

// ===== design/sad_rx_sync.v
// Purpose: Synchronise the receive pin and find its edges
// Assumes: Line idles high
// Notes:   Edge outputs are one-cycle pulses, two cycles after the pin
`timescale 1ns/1ps
module sad_rx_sync (
  // Clock and reset
  input  wire core_clk,
  input  wire rstn,
  // Pin and results
  input  wire serial_receive_pin,
  output wire rx_level,
  output wire rx_rise,
  output wire rx_fall
);
  reg meta_reg;
  reg sync_reg;
  reg last_reg;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= serial_receive_pin;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // The second and third stages feed the edge logic; the first stage does not
  assign rx_level = sync_reg;
  assign rx_rise  = sync_reg & ~last_reg;
  assign rx_fall  = ~sync_reg & last_reg;
endmodule

// ===== design/sad_prescale.v
// Purpose: Base clock and auto-baud counter clock enables
// Assumes: Selection bits are stable while a measurement runs
// Notes:   Free-running divider; enables are one-cycle pulses
`timescale 1ns/1ps
`include "sad_defines.vh"
module sad_prescale (
  // Clock and reset
  input  wire core_clk,
  input  wire rstn,
  // Rate selection
  input  wire wide_rate_select,
  input  wire high_rate_select,
  // Enables
  output wire base_tick,
  output wire abd_tick
);
  reg  [8:0] div_reg;
  wire [3:0] base_log2;

  // Terminal count of the divider for a power-of-two divisor
  function tick_at;
    input [8:0] cnt;
    input [3:0] lg;
    reg   [8:0] msk;
    begin
      msk     = ~(9'h1FF << lg);
      tick_at = ((cnt & msk) == msk);
    end
  endfunction

  // 00 slow, 01/10 mid, 11 fast
  assign base_log2 = (wide_rate_select & high_rate_select) ? `SAD_BASE_FAST_LOG2 :
                     (wide_rate_select | high_rate_select) ? `SAD_BASE_MID_LOG2 :
                                                             `SAD_BASE_SLOW_LOG2;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      div_reg <= 9'h000;
    else
      div_reg <= div_reg + 9'h001;
  end

  assign base_tick = tick_at(div_reg, base_log2);
  // Measurement clock is one eighth of the base clock
  assign abd_tick  = tick_at(div_reg, base_log2 + `SAD_ABD_EXTRA_LOG2);
endmodule

// ===== design/sad_top.v
// Purpose: Auto-baud calibration with rate generator and simple receiver
// Assumes: APB slave with zero wait states; serial_receive_pin synchronous-safe
// Notes:   Registers are at most eight bits wide, in the low byte of each word
// Behaviour
// - Setting autobaud enable starts calibration; receiver stays idle meanwhile.
// - Receive line times the counter; far end sends 55h with five rises.
// - Low rate register starts counting at first rise after the start bit.
// - Fifth rise stores count, clears autobaud enable, sets receive flag.
// - Reading receive buffer clears the flag; software discards the value.
// - During calibration high and low registers form one 16-bit counter.
// - Counter advances at one eighth of the base clock rate.
// - Select 00 gives /512, 01 or 10 /128, 11 /32 counter clock.
// - With wake-on-break set, measure the character after the break.
// - Counter starts at 1; software subtracts one afterwards.
`timescale 1ns/1ps
`include "sad_defines.vh"
module sad_top (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rstn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Serial line
  input  wire        serial_receive_pin,
  // Interrupt and status
  output wire        irq,
  output wire        baud_tick
);
  // Auto-baud states
  localparam [2:0] ABS_IDLE     = 3'h0;
  localparam [2:0] ABS_BRK_FALL = 3'h1;
  localparam [2:0] ABS_BRK_RISE = 3'h2;
  localparam [2:0] ABS_START    = 3'h3;
  localparam [2:0] ABS_FIRST    = 3'h4;
  localparam [2:0] ABS_COUNT    = 3'h5;
  // Receiver states
  localparam [1:0] RXS_IDLE     = 2'h0;
  localparam [1:0] RXS_START    = 2'h1;
  localparam [1:0] RXS_DATA     = 2'h2;
  localparam [1:0] RXS_STOP     = 2'h3;

  reg  [`SAD_CTRL_W-1:0] ctrl_reg;
  reg  [7:0]             rate_low_reg;
  reg  [7:0]             rate_high_reg;
  reg  [7:0]             rx_buf_reg;
  reg  [`SAD_INT_W-1:0]  int_stat_reg;
  reg  [`SAD_INT_W-1:0]  int_mask_reg;
  reg  [2:0]             ab_state_reg;
  reg  [2:0]             edge_cnt_reg;
  reg  [15:0]            rate_cnt_reg;
  reg  [1:0]             rx_state_reg;
  reg  [3:0]             rx_bit_reg;
  reg  [7:0]             rx_shift_reg;
  reg  [31:0]            rd_next;
  reg                    addr_ok;

  wire       rx_level;
  wire       rx_rise;
  wire       rx_fall;
  wire       base_tick;
  wire       abd_tick;
  wire       autobaud_enable;
  wire       wide_rate_select;
  wire       high_rate_select;
  wire       wake_on_break_enable;
  wire       setup_ph;
  wire       access_ph;
  wire       wr_en;
  wire       rd_en;
  wire       wr_ctrl;
  wire       wr_rate_low;
  wire       wr_rate_high;
  wire       wr_int_stat;
  wire       wr_int_mask;
  wire       autobaud_mode;
  wire [15:0] rate_val;
  wire [15:0] rate_pair;
  wire       rate_wrap;
  wire       rx_mid;
  wire       cal_done;
  wire       cal_overflow;
  wire       rx_done;
  wire       rx_buf_read;
  wire [`SAD_INT_W-1:0] int_set;
  wire [`SAD_INT_W-1:0] int_w1c;

  assign autobaud_enable      = ctrl_reg[`SAD_CTRL_AB_EN];
  assign wide_rate_select     = ctrl_reg[`SAD_CTRL_WIDE];
  assign high_rate_select     = ctrl_reg[`SAD_CTRL_HIGH];
  assign wake_on_break_enable = ctrl_reg[`SAD_CTRL_WAKE];
  assign autobaud_mode        = (ab_state_reg != ABS_IDLE);

  sad_rx_sync u_sync (
    .core_clk           (core_clk),
    .rstn               (rstn),
    .serial_receive_pin (serial_receive_pin),
    .rx_level           (rx_level),
    .rx_rise            (rx_rise),
    .rx_fall            (rx_fall)
  );

  sad_prescale u_pre (
    .core_clk         (core_clk),
    .rstn             (rstn),
    .wide_rate_select (wide_rate_select),
    .high_rate_select (high_rate_select),
    .base_tick        (base_tick),
    .abd_tick         (abd_tick)
  );

  // APB: zero wait states, error on unmapped offsets
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~addr_ok;
  assign wr_en     = access_ph & pwrite & addr_ok;
  assign rd_en     = access_ph & ~pwrite & addr_ok;

  // Register hit for one offset; shared by every strobe below
  function hit_reg;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit_reg = (addr == off);
    end
  endfunction

  // Per-register strobes; addr_ok already keeps unmapped offsets out
  assign wr_ctrl      = wr_en & hit_reg(paddr, `SAD_OFF_CTRL);
  assign wr_rate_low  = wr_en & hit_reg(paddr, `SAD_OFF_RATE_LOW);
  assign wr_rate_high = wr_en & hit_reg(paddr, `SAD_OFF_RATE_HIGH);
  assign wr_int_stat  = wr_en & hit_reg(paddr, `SAD_OFF_INT_STAT);
  assign wr_int_mask  = wr_en & hit_reg(paddr, `SAD_OFF_INT_MASK);
  assign rx_buf_read  = rd_en & hit_reg(paddr, `SAD_OFF_RX_BUF);

  always @* begin
    addr_ok = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr)
      `SAD_OFF_CTRL:      rd_next[`SAD_CTRL_W-1:0] = ctrl_reg;
      `SAD_OFF_RATE_LOW:  rd_next[7:0] = rate_low_reg;
      `SAD_OFF_RATE_HIGH: rd_next[7:0] = rate_high_reg;
      `SAD_OFF_RX_BUF:    rd_next[7:0] = rx_buf_reg;
      `SAD_OFF_INT_STAT:  rd_next[`SAD_INT_W-1:0] = int_stat_reg;
      `SAD_OFF_INT_MASK:  rd_next[`SAD_INT_W-1:0] = int_mask_reg;
      `SAD_OFF_STATUS: begin
        rd_next[2:0] = ab_state_reg;
        rd_next[4:3] = rx_state_reg;
        rd_next[5]   = rx_level;
      end
      default:            addr_ok = 1'b0;
    endcase
  end

  // Read data is caught in the setup cycle so it is a flop in the access cycle
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      prdata <= 32'h0000_0000;
    else if (setup_ph)
      prdata <= rd_next;
  end

  // Control register; hardware clears the enable when a measurement ends
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `SAD_CTRL_RST;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= pwdata[`SAD_CTRL_W-1:0];
      if (cal_done)
        ctrl_reg[`SAD_CTRL_AB_EN] <= 1'b0;
    end
  end

  // Auto-baud sequencer
  assign rate_pair    = {rate_high_reg, rate_low_reg};
  assign cal_done     = (ab_state_reg == ABS_COUNT) && rx_rise &&
                        (edge_cnt_reg == `SAD_EDGE_COUNT - 3'h1);
  // Overflow counts only a real wrap, not the edge that freezes the pair
  assign cal_overflow = (ab_state_reg == ABS_COUNT) && abd_tick && !cal_done &&
                        (rate_pair == 16'hFFFF);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ab_state_reg <= ABS_IDLE;
      edge_cnt_reg <= 3'h0;
    end else if (!autobaud_enable) begin
      ab_state_reg <= ABS_IDLE;
      edge_cnt_reg <= 3'h0;
    end else begin
      case (ab_state_reg)
        ABS_IDLE: begin
          // Enable set starts the sequence
          if (wake_on_break_enable)
            ab_state_reg <= ABS_BRK_FALL;
          else
            ab_state_reg <= ABS_START;
        end
        ABS_BRK_FALL: begin
          if (rx_fall)
            ab_state_reg <= ABS_BRK_RISE;
        end
        ABS_BRK_RISE: begin
          // Break ends on its rise; the next character is measured
          if (rx_rise)
            ab_state_reg <= ABS_START;
        end
        ABS_START: begin
          // A line held low keeps the sequence here; clearing the enable aborts it
          if (rx_fall)
            ab_state_reg <= ABS_FIRST;
        end
        ABS_FIRST: begin
          if (rx_rise) begin
            ab_state_reg <= ABS_COUNT;
            edge_cnt_reg <= 3'h1;
          end
        end
        ABS_COUNT: begin
          // Falling edges are not counted
          if (rx_rise) begin
            edge_cnt_reg <= edge_cnt_reg + 3'h1;
            if (cal_done)
              ab_state_reg <= ABS_IDLE;
          end
        end
        default: ab_state_reg <= ABS_IDLE;
      endcase
    end
  end

  // Rate period registers: software value, or 16-bit counter while measuring
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rate_low_reg  <= `SAD_RATE_RST;
      rate_high_reg <= `SAD_RATE_RST;
    end else if (ab_state_reg == ABS_FIRST && rx_rise && autobaud_enable) begin
      {rate_high_reg, rate_low_reg} <= `SAD_COUNT_START;
    end else if (ab_state_reg == ABS_COUNT && autobaud_enable) begin
      // Count stands still from the fifth edge on
      if (abd_tick && !cal_done)
        {rate_high_reg, rate_low_reg} <= rate_pair + 16'h0001;
    end else if (!autobaud_mode) begin
      // Software writes are dropped while the pair is a counter
      if (wr_rate_low)
        rate_low_reg <= pwdata[7:0];
      if (wr_rate_high)
        rate_high_reg <= pwdata[7:0];
    end
  end

  // Rate generator: one tick per value plus one base periods
  // Compare is >= so a smaller value written mid-period wraps at the next base tick
  assign rate_val  = wide_rate_select ? rate_pair : {8'h00, rate_low_reg};
  assign rate_wrap = base_tick && (rate_cnt_reg >= rate_val);
  assign baud_tick = rate_wrap & ~autobaud_mode;
  assign rx_mid    = base_tick && (rate_cnt_reg == {1'b0, rate_val[15:1]});

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn)
      rate_cnt_reg <= 16'h0000;
    else if (autobaud_mode || (rx_state_reg == RXS_IDLE && rx_fall))
      rate_cnt_reg <= 16'h0000;   // realign on the start edge
    else if (rate_wrap)
      rate_cnt_reg <= 16'h0000;
    else if (base_tick)
      rate_cnt_reg <= rate_cnt_reg + 16'h0001;
  end

  // Receiver samples at mid-bit; held idle during calibration
  assign rx_done = (rx_state_reg == RXS_STOP) && rx_mid && rx_level;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_state_reg <= RXS_IDLE;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_buf_reg   <= 8'h00;
    end else if (autobaud_enable) begin
      rx_state_reg <= RXS_IDLE;
      rx_bit_reg   <= 4'h0;
    end else begin
      case (rx_state_reg)
        RXS_IDLE: begin
          if (rx_fall)
            rx_state_reg <= RXS_START;
        end
        RXS_START: begin
          // A start bit that is high again at mid-bit is a glitch
          if (rx_mid)
            rx_state_reg <= rx_level ? RXS_IDLE : RXS_DATA;
          rx_bit_reg <= 4'h0;
        end
        RXS_DATA: begin
          if (rx_mid) begin
            rx_shift_reg <= {rx_level, rx_shift_reg[7:1]};
            rx_bit_reg   <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h7)
              rx_state_reg <= RXS_STOP;
          end
        end
        RXS_STOP: begin
          // A low stop bit drops the character
          if (rx_mid) begin
            rx_state_reg <= RXS_IDLE;
            if (rx_level)
              rx_buf_reg <= rx_shift_reg;
          end
        end
        default: rx_state_reg <= RXS_IDLE;
      endcase
    end
  end

  // Interrupt status: set wins over any clear in the same cycle
  assign int_w1c     = wr_int_stat ?
                       pwdata[`SAD_INT_W-1:0] : {`SAD_INT_W{1'b0}};
  assign int_set     = {cal_overflow, cal_done, cal_done | rx_done};

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      int_stat_reg <= {`SAD_INT_W{1'b0}};
      int_mask_reg <= `SAD_MASK_RST;
    end else begin
      // Buffer read clears the receive flag
      int_stat_reg <= int_set |
                      (int_stat_reg & ~int_w1c &
                       ~({{(`SAD_INT_W-1){1'b0}}, rx_buf_read}));
      if (wr_int_mask)
        int_mask_reg <= pwdata[`SAD_INT_W-1:0];
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);
endmodule

// ===== tb/sad_top_asserts.sv
// Purpose: Port-level checks for sad_top
// Assumes: Bus master keeps the two-phase APB handshake
// Notes:   Mask is mirrored from bus writes to judge irq
`timescale 1ns/1ps
`include "sad_defines.vh"
module sad_chk (
  // Clock and reset
  input logic        core_clk,
  input logic        rstn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  // Line and status
  input logic        serial_receive_pin,
  input logic        irq,
  input logic        baud_tick
);
  logic [2:0] mask_reg;
  wire        acc    = psel && penable;
  wire        setup  = psel && !penable;
  wire        mapped = paddr[1:0] == 2'h0 && paddr <= 8'h18;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      mask_reg <= 3'h0;
    else if (acc && pwrite && paddr == `SAD_OFF_INT_MASK)
      mask_reg <= pwdata[2:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_ready_zero_wait: assert property (acc |-> pready) else $error("pready low");
  a_unmapped_error: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
  a_error_only_unmapped: assert property (pslverr |-> acc && !mapped) else $error("stray pslverr");
  a_unmapped_zero: assert property (setup && !pwrite && !mapped |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_bits_zero: assert property (prdata[31:8] == 24'h0) else $error("prdata upper bits");
  a_prdata_hold: assert property (!setup |=> $stable(prdata)) else $error("prdata moved");
  a_mask_readback: assert property (setup && !pwrite && paddr == `SAD_OFF_INT_MASK
    |=> prdata[2:0] == mask_reg) else $error("mask readback");
  a_irq_needs_mask: assert property (irq |-> mask_reg != 3'h0) else $error("irq while masked");
  a_idle_measure: assert property (acc && pwrite && paddr == `SAD_OFF_CTRL && pwdata[0]
    |-> ##2 !baud_tick [*8]) else $error("tick while measuring");
  a_tick_spacing: assert property (baud_tick |=> !baud_tick [*3]) else $error("ticks too close");
  c_irq_raised: cover property ($rose(irq));
  c_unmapped: cover property (acc && pslverr);
  c_tick: cover property (baud_tick);
endmodule

bind sad_top sad_chk i_sad_chk (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .serial_receive_pin, .irq, .baud_tick);

// ===== tb/sad_sync_sender.sv
// Purpose: Remote transmitter that sends the 55h sync character
// Assumes: Line idles high through a pull-up
// Notes:   Bit time in core clock cycles; optional break first
`timescale 1ns/1ps
module sad_sync_sender (
  // Clock
  input  logic        core_clk,
  // Control
  input  logic        go,
  input  logic [15:0] bit_cycles,
  input  logic        with_break,
  output logic        busy,
  // Line
  output logic        serial_receive_pin
);
  task automatic hold(input logic lvl, input int bits);
    serial_receive_pin <= lvl;
    repeat (bits * bit_cycles) @(posedge core_clk);
  endtask
  // One process drives the line and busy, so each has a single driver
  initial begin
    serial_receive_pin <= 1'b1;
    busy <= 1'b0;
    forever begin
      @(posedge core_clk);
      if (go && !busy) begin
        busy <= 1'b1;
        if (with_break) begin
          hold(1'b0, 13);
          hold(1'b1, 1);
        end
        hold(1'b0, 1);
        // LSB first, so even bits are ones: five rises counting the stop edge
        for (int i = 0; i < 8; i++)
          hold(!i[0], 1);
        hold(1'b1, 1);
        busy <= 1'b0;
      end
    end
  end
endmodule

// ===== tb/tb_serial_autobaud_detect.sv
// Purpose: Self-checking bench for sad_top
// Assumes: Zero-wait APB slave, 10 MHz core clock
// Notes:   Measured counts may differ by one, the divider free-runs
`timescale 1ns/1ps
`include "sad_defines.vh"
module tb_serial_autobaud_detect;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready, pslverr, irq, baud_tick, rx_line, busy, err_seen;
  logic [31:0] prdata, rd;
  logic        go = 1'b0;
  logic        brk = 1'b0;
  logic [15:0] bit_cyc = 16'h0;
  int          err_total = 0;
  int          num_checks = 0;
  int          n;
  always #50 core_clk = ~core_clk;
  sad_top i_sad_top (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .serial_receive_pin(rx_line), .irq, .baud_tick);
  sad_sync_sender i_sad_sync_sender (.core_clk, .go, .bit_cycles(bit_cyc), .with_break(brk),
    .busy, .serial_receive_pin(rx_line));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t %s", $time, what);
    end
  endtask
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    for (n = 0; n < lim && sig !== lvl; n++)
      @(negedge core_clk);
    if (sig !== lvl) begin
      check(1'b0, "wait timed out");
      report_and_stop();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      check(1'b0, "no pready");
      report_and_stop();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic int abd_div(input logic [1:0] sel);
    return sel == 2'b00 ? 512 : (sel == 2'b11 ? 32 : 128);
  endfunction
  function automatic int tick_period(input int val, input int base);
    return (val + 1) * base;
  endfunction
  // Busy is seen rising first, so the wait for its fall cannot pass at once
  task automatic send(input int cyc, input logic wake, input int lim);
    @(posedge core_clk);
    bit_cyc <= 16'(cyc);
    brk <= wake;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    wait_for(busy, 1'b1, 4);
    wait_for(busy, 1'b0, lim);
  endtask
  task automatic measure(input logic [1:0] sel, input logic wake, input int k);
    int div, got;
    logic [2:0] m;
    logic [7:0] lo;
    div = abd_div(sel);
    m = 3'($urandom);
    apb(1'b1, `SAD_OFF_INT_MASK, {29'h0, m});
    apb(1'b0, `SAD_OFF_INT_MASK, 32'h0);
    check(rd[2:0] === m, "mask readback");
    apb(1'b1, `SAD_OFF_CTRL, {28'h0, wake, sel[0], sel[1], 1'b1});
    send(div * k / 8, wake, 20 * div * k);
    apb(1'b0, `SAD_OFF_CTRL, 32'h0);
    check(rd[0] === 1'b0, "enable not cleared");
    apb(1'b0, `SAD_OFF_RATE_LOW, 32'h0);
    lo = rd[7:0];
    apb(1'b0, `SAD_OFF_RATE_HIGH, 32'h0);
    check(k > 254 || rd[7:0] === 8'h00, "high byte set without overflow");
    got = int'({rd[7:0], lo}) - 1;
    check(got >= k - 1 && got <= k + 1, "measured count");
    apb(1'b0, `SAD_OFF_INT_STAT, 32'h0);
    check(rd[2:0] === 3'b011, "flags after measurement");
    check(irq === |(m & 3'b011), "irq level");
    apb(1'b0, `SAD_OFF_RX_BUF, 32'h0);
    apb(1'b0, `SAD_OFF_INT_STAT, 32'h0);
    check(rd[2:0] === 3'b010, "flag kept after buffer read");
    apb(1'b1, `SAD_OFF_INT_STAT, 32'h7);
    @(negedge core_clk);
    check(irq === 1'b0, "irq after clear");
  endtask
  initial begin
    void'($urandom(50008));
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    apb(1'b0, 8'h1C, 32'h0);
    check(err_seen === 1'b1 && rd === 32'h0, "unmapped access");
    for (int s = 0; s < 4; s++)
      measure(2'(s), 1'b0, 4 + $urandom % 12);
    measure(2'b01, 1'b0, 260);
    measure(2'b11, 1'b1, 4 + $urandom % 30);
    apb(1'b1, `SAD_OFF_RATE_LOW, 32'h3);
    apb(1'b1, `SAD_OFF_CTRL, 32'h4);
    wait_for(baud_tick, 1'b1, 400);
    @(negedge core_clk);
    wait_for(baud_tick, 1'b1, 400);
    check(n + 1 == tick_period(3, 16), "normal tick period");
    // Normal reception at the same rate: the sync character lands in the buffer
    send(tick_period(3, 16), 1'b0, 2000);
    apb(1'b0, `SAD_OFF_INT_STAT, 32'h0);
    check(rd[0] === 1'b1, "no receive flag after character");
    apb(1'b0, `SAD_OFF_RX_BUF, 32'h0);
    check(rd[7:0] === 8'h55, "received byte");
    report_and_stop();
  end
endmodule
